// ===== rtl/sdt_master.sv
// telegram master: wishbone registers, telegram build, reply check
`timescale 1ns/1ps
`include "sdt_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - telegram starts with start byte 0x02
// R2 - count byte equals bytes after it
// R3 - mode bits clear: only matching node answers
// R4 - broadcast bit: all act, no address check
// R5 - mirror bit: addressed node echoes telegram unchanged
// R6 - check byte is XOR of preceding bytes
// R7 - one character is eleven bit times
// R8 - idle gap over two characters between telegrams
// R9 - gap inside telegram below start delay
// R10 - node address configurable 0 to 30
// R11 - baud 2400 to 115200, timings scale
// R12 - process words configurable 0 to 8
// R13 - parameter channel 0, 3, 4 or variable
// R14 - off-time monitor 0 to 65535 ms; the master has no off-time monitor
// R15 - parameter words first, then process words
// R16 - identifier, index, then value words
// R17 - 16-bit value one word, 32-bit two
// R18 - byte values sent as zero-extended words
// R19 - fixed channel length must match exactly
// R20 - variable mode sends only needed words
// R21 - prefer four words over three when fixed
// R22 - one setting copy per port
// R23 - residual time limit 1.5 times (n+3) characters
// R24 - reply starts after start delay, before 20 ms
// R25 - off-time counter raises process timeout fault; the master has no off-time counter, only reply and residual timeouts
// R26 - character: start, 8 data, even parity, stop
// R27 - bad telegrams are discarded silently
module sdt_master import sdt_pkg::*; #(
  parameter int BUF_AW   = 6,
  parameter int RESP_CYC = `SDT_RESP_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [9:0]  wb_adr,
  input  wire logic [31:0] wb_dat_w,
  input  wire logic [3:0]  wb_sel,
  output logic [31:0]      wb_dat_r,
  output logic             wb_ack,
  // serial line, one instance per port
  output logic             line_txd,
  output logic             line_oe_n,
  input  wire logic        line_rxd
);
  localparam int DEPTH = 1 << BUF_AW;

  sdt_state_t   state_reg, state_next;
  logic [31:0]  cfg_reg, cfg_next, div_reg, div_next;
  logic [8:0]   flg_reg, flg_next, flg_set;
  logic [7:0]   idx_reg, idx_next, chk_reg, chk_next, count_reg, count_next;
  logic [4:0]   gap_reg, gap_next;
  logic [19:0]  tmr_reg, tmr_next;
  logic [15:0]  tick_reg, tick_next;
  logic         ack_next;
  logic [31:0]  rd_next;
  logic [7:0]   tx_buf [DEPTH];
  logic [7:0]   rx_buf [DEPTH];
  logic         tx_valid, tx_ready, rx_valid, rx_busy, tick;
  logic [7:0]   tx_byte;
  sdt_rx_char_t rx_char;
  logic         req, wr, start, clr, busy;
  logic [7:0]   adr_byte, n_bytes;
  logic [3:0]   proc_w, par_w;
  logic [6:0]   par_set;
  logic         cfg_ok, bcast, rx_ok;
  logic [15:0]  resid_lim;
  logic [BUF_AW-1:0] rx_wa;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  assign adr_byte = cfg_reg[7:0];
  assign proc_w   = cfg_reg[11:8];
  assign par_set  = cfg_reg[22:16];
  // variable channel takes its word count from the task, fixed from setting
  assign par_w    = (par_set == `SDT_PAR_VAR) ? cfg_reg[27:24] : par_set[3:0]; // R20 R19
  // five-bit sum: up to 15 variable words plus 8 process words
  assign n_bytes  = {2'b00, 5'(par_w) + 5'(proc_w), 1'b0}; // R15 R17
  assign bcast    = adr_byte[`SDT_ADR_BCAST];
  assign cfg_ok   = (adr_byte[4:0] <= `SDT_NODE_MAX) && (proc_w <= `SDT_PROC_MAX) // R10 R12
                 && (par_set == `SDT_PAR_NONE || par_set == `SDT_PAR_3W // R13
                     || par_set == `SDT_PAR_4W || par_set == `SDT_PAR_VAR)
                 && (div_reg[15:0] >= `SDT_DIV_MIN) && (div_reg[15:0] <= `SDT_DIV_MAX) // R11
                 && (32'(n_bytes) <= 32'(DEPTH));
  assign busy     = (state_reg != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: answer one cycle after the request, unmapped reads zero
  assign req   = wb_cyc && wb_stb && !wb_ack;
  assign wr    = wb_cyc && wb_stb && wb_we && wb_ack;
  assign start = wr && wb_adr == `SDT_OFS_CTRL && wb_sel[0] && wb_dat_w[`SDT_CTRL_START];
  assign clr   = wr && wb_adr == `SDT_OFS_CTRL && wb_sel[0] && wb_dat_w[`SDT_CTRL_CLEAR];
  assign ack_next = req;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (wb_adr[9:`SDT_BUF_SEL_BIT] == 2'b01) begin
      rd_next = {24'h000000, rx_buf[wb_adr[BUF_AW+1:2]]};
    end else begin
      unique case (wb_adr)
        `SDT_OFS_CFG:  rd_next = cfg_reg;
        `SDT_OFS_BAUD: rd_next = div_reg;
        `SDT_OFS_STAT: rd_next = {count_reg, 7'h00, busy, 7'h00, flg_reg};
        default:       rd_next = 32'h0000_0000;
      endcase
    end
  end

  // settings are frozen while a telegram is in flight
  assign cfg_next = (wr && !busy && wb_adr == `SDT_OFS_CFG) ?
                    merge(cfg_reg, wb_dat_w, wb_sel) : cfg_reg;
  assign div_next = (wr && !busy && wb_adr == `SDT_OFS_BAUD) ?
                    merge(div_reg, wb_dat_w, wb_sel) : div_reg;

  // words go out in buffer address order, not load order: identifier, index, values
  always_ff @(posedge clk) begin
    if (wr && !busy && wb_adr[9:`SDT_BUF_SEL_BIT] == 2'b01 && wb_sel[0]) begin
      tx_buf[wb_adr[BUF_AW+1:2]] <= wb_dat_w[7:0]; // R16 R18
    end
    if (state_reg == ST_RECV && rx_ok && idx_reg >= 8'h03 && idx_reg < count_reg + 8'h01) begin
      rx_buf[rx_wa] <= rx_char.data;
    end
  end
  assign rx_wa = BUF_AW'(idx_reg - 8'h03);

  ////////////////////////////////////////////////////////////////////////////
  // line side
  sdt_uart_tx u_tx (
    .clk       (clk),
    .reset_n   (reset_n),
    .baud_div  (div_reg[15:0]),
    .tx_valid  (tx_valid),
    .tx_data   (tx_byte),
    .tx_ready  (tx_ready),
    .line_txd  (line_txd),
    .line_oe_n (line_oe_n)
  );

  sdt_uart_rx u_rx (
    .clk      (clk),
    .reset_n  (reset_n),
    .baud_div (div_reg[15:0]),
    .line_rxd (line_rxd),
    .rx_valid (rx_valid),
    .rx_char  (rx_char),
    .rx_busy  (rx_busy)
  );

  // the own transmission echoes on a half-duplex bus and is not a reply
  assign rx_ok     = rx_valid && tx_ready && line_oe_n;
  assign tick      = (tick_reg == div_reg[15:0] - 16'h0001);
  assign tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
  assign tx_valid  = (state_reg == ST_SEND) && (idx_reg <= n_bytes + 8'h03);
  // 1.5 * (n + 3) characters of 11 bits, with n + 3 equal to count + 1
  assign resid_lim = 16'((17'(count_reg) + 17'h1) * 17'd33 >> 1); // R23 R7

  always_comb begin
    unique case (idx_reg)
      8'h00:   tx_byte = `SDT_STX; // R1
      8'h01:   tx_byte = n_bytes + 8'h02; // R2
      8'h02:   tx_byte = adr_byte; // R3 R4 R5
      default: tx_byte = (idx_reg == n_bytes + 8'h03) ? chk_reg // R6
                         : tx_buf[BUF_AW'(idx_reg - 8'h03)];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // telegram sequencer
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    chk_next   = chk_reg;
    count_next = count_reg;
    gap_next   = gap_reg;
    tmr_next   = tmr_reg;
    flg_set    = 9'h000;
    unique case (state_reg)
      ST_IDLE: begin
        if (start && cfg_ok) begin
          state_next = ST_GAP;
          gap_next   = 5'h00;
        end else if (start) begin
          flg_set[`SDT_ST_CFG] = 1'b1;
        end
      end
      ST_GAP: begin
        // any line activity restarts the start delay
        if (rx_busy) begin
          gap_next = 5'h00; // R8
        end else if (gap_reg == `SDT_GAP_BITS) begin
          state_next = ST_SEND;
          idx_next   = 8'h00;
          chk_next   = 8'h00;
        end else if (tick) begin
          gap_next = gap_reg + 5'h01; // R8
        end
      end
      ST_SEND: begin
        // characters leave back to back, so no inner gap reaches the start delay
        if (tx_valid && tx_ready) begin // R9
          chk_next = chk_reg ^ tx_byte; // R6
          idx_next = idx_reg + 8'h01;
        end else if (!tx_valid && tx_ready && line_oe_n) begin
          // a broadcast is never answered
          state_next = bcast ? ST_IDLE : ST_WAIT; // R4
          flg_set[`SDT_ST_DONE] = bcast;
          tmr_next = 20'h00000;
        end
      end
      ST_WAIT: begin
        tmr_next = tmr_reg + 20'h00001;
        if (rx_ok) begin
          state_next = (rx_char.data == `SDT_STX) ? ST_RECV : ST_IDLE; // R1 R27
          flg_set[`SDT_ST_START] = (rx_char.data != `SDT_STX);
          idx_next = 8'h01;
          chk_next = rx_char.data;
          count_next = 8'hff;
          tmr_next = 20'h00000;
        end else if (tmr_reg == 20'(RESP_CYC - 1)) begin
          state_next = ST_IDLE; // R24
          flg_set[`SDT_ST_TIMEOUT] = 1'b1;
        end
      end
      ST_RECV: begin
        if (tick) tmr_next = tmr_reg + 20'h00001;
        if (rx_ok && (rx_char.par_err || rx_char.frm_err)) begin
          state_next = ST_IDLE; // R26
        end else if (rx_ok) begin
          chk_next = chk_reg ^ rx_char.data;
          idx_next = idx_reg + 8'h01;
          if (idx_reg == 8'h01) begin
            count_next = rx_char.data; // R2
            if (rx_char.data < 8'h02) begin
              state_next = ST_IDLE;
              flg_set[`SDT_ST_LEN] = 1'b1;
            end
          end else if (idx_reg == 8'h02) begin
            flg_set[`SDT_ST_ADDR] = (rx_char.data[4:0] != adr_byte[4:0]); // R3 R5
          end else if (idx_reg == count_reg + 8'h01) begin
            state_next = ST_IDLE;
            flg_set[`SDT_ST_DONE] = 1'b1;
            flg_set[`SDT_ST_CHK]  = (rx_char.data != chk_reg); // R6 R27
          end
        end else if (tmr_reg > 20'(resid_lim)) begin
          state_next = ST_IDLE; // R23
          flg_set[`SDT_ST_TIMEOUT] = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    flg_set[`SDT_ST_PARITY] = rx_valid && rx_char.par_err; // R26
    flg_set[`SDT_ST_FRAME]  = rx_valid && rx_char.frm_err; // R26
    // an event in the clearing cycle survives
    flg_next = (clr ? 9'h000 : flg_reg) | flg_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cfg_reg   <= `SDT_CFG_RST; // R21
      div_reg   <= {16'h0000, `SDT_DIV_RST};
      flg_reg   <= 9'h000;
      idx_reg   <= 8'h00;
      chk_reg   <= 8'h00;
      count_reg <= 8'h00;
      gap_reg   <= 5'h00;
      tmr_reg   <= 20'h00000;
      tick_reg  <= 16'h0000;
      wb_ack    <= 1'b0;
      wb_dat_r  <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
      div_reg   <= div_next;
      flg_reg   <= flg_next;
      idx_reg   <= idx_next;
      chk_reg   <= chk_next;
      count_reg <= count_next;
      gap_reg   <= gap_next;
      tmr_reg   <= tmr_next;
      tick_reg  <= tick_next;
      wb_ack    <= ack_next;
      wb_dat_r  <= req ? rd_next : wb_dat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_stx_first: assert property (@(posedge clk) disable iff (!reset_n) // R1
    $rose(state_reg == ST_SEND) |-> tx_valid && tx_byte == `SDT_STX)
    else $error("first byte is not start byte");
  a_count_value: assert property (@(posedge clk) disable iff (!reset_n) // R2
    tx_valid && tx_ready && idx_reg == 8'h01 |-> tx_byte == n_bytes + 8'h02)
    else $error("count byte wrong");
  a_gap_before: assert property (@(posedge clk) disable iff (!reset_n) // R8
    $rose(state_reg == ST_SEND) |-> $past(gap_reg) == `SDT_GAP_BITS && $past(state_reg) == ST_GAP)
    else $error("telegram sent without start delay");
  a_chk_sent: assert property (@(posedge clk) disable iff (!reset_n) // R6
    tx_valid && tx_ready && idx_reg == n_bytes + 8'h03 |-> tx_byte == chk_reg)
    else $error("check byte not the running xor");
  a_bcast_idle: assert property (@(posedge clk) disable iff (!reset_n) // R4
    state_reg == ST_SEND && state_next != ST_SEND && bcast |=> state_reg == ST_IDLE
    && flg_reg[`SDT_ST_DONE])
    else $error("broadcast waits for a reply");
  a_cfg_refuse: assert property (@(posedge clk) disable iff (!reset_n) // R13
    state_reg == ST_IDLE && start && !cfg_ok |=> state_reg == ST_IDLE && flg_reg[`SDT_ST_CFG])
    else $error("bad settings not refused");
  a_resid_limit: assert property (@(posedge clk) disable iff (!reset_n) // R23
    state_reg == ST_RECV && !rx_ok && tmr_reg > 20'(resid_lim) |=> state_reg == ST_IDLE
    && flg_reg[`SDT_ST_TIMEOUT])
    else $error("residual time overrun missed");
  a_chk_check: assert property (@(posedge clk) disable iff (!reset_n) // R27
    state_reg == ST_RECV && rx_ok && !rx_char.par_err && !rx_char.frm_err
    && idx_reg == count_reg + 8'h01 && rx_char.data != chk_reg |=> flg_reg[`SDT_ST_CHK])
    else $error("bad check byte not flagged");
endmodule // sdt_master

// ===== rtl/sdt_cfg.svh
// constants for the serial drive telegram master: offsets, fields, timing
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH
// telegram framing
`define SDT_STX            8'h02
`define SDT_ADR_BCAST      5
`define SDT_ADR_MIRROR     6
`define SDT_ADR_SPECIAL    7
`define SDT_NODE_MAX       5'h1e
`define SDT_PROC_MAX       4'h8
`define SDT_PAR_NONE       7'h00
`define SDT_PAR_3W         7'h03
`define SDT_PAR_4W         7'h04
`define SDT_PAR_VAR        7'h7f
// character and gap timing in bit times
`define SDT_BITS_PER_CHAR  11
`define SDT_GAP_BITS       5'h17
// clock and response timing
`define SDT_CLK_HZ         50000000
`define SDT_RESP_DELAY_US  20000
`define SDT_RESP_CYC       (`SDT_RESP_DELAY_US * (`SDT_CLK_HZ / 1000000))
// baud divider limits: clocks per bit at 115200 and at 2400 baud
`define SDT_DIV_MIN        16'h01b2
`define SDT_DIV_MAX        16'h5161
`define SDT_DIV_RST        16'h1458
// register byte offsets
`define SDT_OFS_CTRL       10'h000
`define SDT_OFS_CFG        10'h004
`define SDT_OFS_BAUD       10'h008
`define SDT_OFS_STAT       10'h00c
`define SDT_BUF_SEL_BIT    8
// reset values and fields
`define SDT_CFG_RST        32'h0004_0200
`define SDT_CTRL_START     0
`define SDT_CTRL_CLEAR     1
`define SDT_ST_DONE        0
`define SDT_ST_TIMEOUT     1
`define SDT_ST_CHK         2
`define SDT_ST_START       3
`define SDT_ST_PARITY      4
`define SDT_ST_FRAME       5
`define SDT_ST_CFG         6
`define SDT_ST_ADDR        7
`define SDT_ST_LEN         8
`define SDT_ST_BUSY        16
`define SDT_ST_COUNT_LSB   24
`endif

// ===== rtl/sdt_pkg.sv
// types shared by the serial drive telegram master
package sdt_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
  } sdt_rx_char_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAP  = 5'h02,
    ST_SEND = 5'h04,
    ST_WAIT = 5'h08,
    ST_RECV = 5'h10
  } sdt_state_t;
endpackage

// ===== rtl/sdt_uart_tx.sv
// character transmitter: start, 8 data lsb first, even parity, stop
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_uart_tx import sdt_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // character request
  input  wire logic [15:0] baud_div,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  // line
  output logic             line_txd,
  output logic             line_oe_n
);
  logic [10:0] shift_reg, shift_next;
  logic [3:0]  bit_reg, bit_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        busy_reg, busy_next;

  assign tx_ready = !busy_reg;

  always_comb begin
    shift_next = shift_reg;
    bit_next   = bit_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    if (!busy_reg && tx_valid) begin
      shift_next = {1'b1, ^tx_data, tx_data, 1'b0}; // R26
      bit_next   = 4'h0;
      cnt_next   = 16'h0000;
      busy_next  = 1'b1;
    end else if (busy_reg) begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg == baud_div - 16'h0001) begin
        cnt_next   = 16'h0000;
        shift_next = {1'b1, shift_reg[10:1]};
        bit_next   = bit_reg + 4'h1;
        if (bit_reg == 4'(`SDT_BITS_PER_CHAR - 1)) begin // R7
          busy_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= 11'h7ff;
      bit_reg   <= 4'h0;
      cnt_reg   <= 16'h0000;
      busy_reg  <= 1'b0;
      line_txd  <= 1'b1;
      line_oe_n <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      line_txd  <= busy_next ? shift_next[0] : 1'b1;
      line_oe_n <= !busy_next;
    end
  end
endmodule // sdt_uart_tx

// ===== rtl/sdt_uart_rx.sv
// character receiver with two-flop input sync, parity and stop check
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_uart_rx import sdt_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // line
  input  wire logic [15:0] baud_div,
  input  wire logic        line_rxd,
  // received character
  output logic             rx_valid,
  output sdt_rx_char_t     rx_char,
  output logic             rx_busy
);
  logic        s1_reg, s2_reg, s3_reg;
  logic [10:0] sh_reg, sh_next;
  logic [3:0]  bit_reg, bit_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        act_reg, act_next;
  logic        vld_next;
  sdt_rx_char_t chr_next;

  assign rx_busy = act_reg;

  always_comb begin
    sh_next  = sh_reg;
    bit_next = bit_reg;
    cnt_next = cnt_reg;
    act_next = act_reg;
    vld_next = 1'b0;
    chr_next = rx_char;
    if (!act_reg) begin
      if (s3_reg && !s2_reg) begin
        act_next = 1'b1;
        bit_next = 4'h0;
        cnt_next = {1'b0, baud_div[15:1]};
      end
    end else if (cnt_reg == 16'h0000) begin
      cnt_next = baud_div - 16'h0001;
      sh_next  = {s2_reg, sh_reg[10:1]};
      bit_next = bit_reg + 4'h1;
      // a glitch that is high at mid start bit is not a character
      if (bit_reg == 4'h0 && s2_reg) begin
        act_next = 1'b0;
      end else if (bit_reg == 4'(`SDT_BITS_PER_CHAR - 1)) begin // R7
        act_next         = 1'b0;
        vld_next         = 1'b1;
        chr_next.data    = sh_next[8:1];
        chr_next.par_err = ^sh_next[9:1]; // R26
        chr_next.frm_err = !s2_reg; // R26
      end
    end else begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      s3_reg   <= 1'b1;
      sh_reg   <= 11'h000;
      bit_reg  <= 4'h0;
      cnt_reg  <= 16'h0000;
      act_reg  <= 1'b0;
      rx_valid <= 1'b0;
      rx_char  <= '0;
    end else begin
      s1_reg   <= line_rxd;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sh_reg   <= sh_next;
      bit_reg  <= bit_next;
      cnt_reg  <= cnt_next;
      act_reg  <= act_next;
      rx_valid <= vld_next;
      rx_char  <= chr_next;
    end
  end
endmodule // sdt_uart_rx

// ===== dv/sdt_drive_model.sv
// behavioural drive slave: takes telegrams off the line and echoes the addressed ones
`timescale 1ns/1ps
module sdt_drive_model #(
  parameter int BIT  = 434,
  parameter int NODE = 5
) (
  // clock
  input  wire logic clk,
  // line from the master
  input  wire logic line_txd,
  input  wire logic line_oe_n,
  // line back to the master
  output logic      slave_txd,
  output logic      slave_oe_n
);
  logic [7:0] t [0:71];
  logic       ok;
  logic       bad;
  logic [7:0] x;
  int         n;
  int         cycle_cnt = 0;
  int         start_cnt;

  // no off-time monitor: a zero setting switches it off
  always @(posedge clk) cycle_cnt <= cycle_cnt + 1;

  ////////////////////////////////////////
  task automatic get(output logic [7:0] b, output logic good);
    logic [10:0] f;
    while (!(line_txd === 1'b0 && line_oe_n === 1'b0)) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 11; k++) begin
      f[k] = line_txd;
      if (k < 10) repeat (BIT) @(posedge clk);
    end
    b    = f[8:1];
    good = !f[0] && f[10] && (f[9] == ^b);
  endtask

  task automatic put(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      slave_txd <= f[k];
      repeat (BIT) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////
  // framing is by start byte and count only, so a broken telegram may swallow the next
  initial begin
    slave_txd  = 1'b1;
    slave_oe_n = 1'b1;
    forever begin
      get(t[0], ok);
      if (!ok || t[0] !== 8'h02) continue;
      start_cnt = cycle_cnt;
      get(t[1], ok);
      n = int'(t[1]);
      if (!ok || n < 2 || n > 69) continue;
      bad = 1'b0;
      x   = t[0] ^ t[1];
      for (int i = 2; i < n + 2; i++) begin
        get(t[i], ok);
        bad |= !ok;
        if (i < n + 1) x ^= t[i];
      end
      if (bad || x !== t[n + 1]) continue;
      // residual time from the start byte: 1.5 * (data + 3) characters of 11 bits
      if (cycle_cnt - start_cnt > 33 * (n + 1) * BIT / 2) continue;
      if (t[2][5] || t[2][4:0] != 5'(NODE)) continue;
      repeat (24 * BIT) @(posedge clk);
      slave_oe_n <= 1'b0;
      for (int i = 0; i < n + 2; i++) put(t[i]);
      slave_oe_n <= 1'b1;
    end
  end
endmodule // sdt_drive_model

// ===== dv/sdt_master_tb_top.sv
// bench for the telegram master: register sequences against the drive model
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_master_tb_top;
  localparam int LIMIT = 120000;
  logic        clk      = 1'b0;
  logic        reset_n  = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [9:0]  wb_adr   = 10'h000;
  logic [31:0] wb_dat_w = 32'h0;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        line_txd;
  logic        line_oe_n;
  logic        line_rxd;
  logic        slave_txd;
  logic        slave_oe_n;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;
  logic [31:0] bad_cfg [3] = '{32'h0000_011f, 32'h0000_0905, 32'h0005_0105};

  always #10 clk = ~clk;
  // a released bus is biased high
  assign line_rxd = !line_oe_n ? line_txd : (!slave_oe_n ? slave_txd : 1'b1);

  sdt_master #(.BUF_AW(6), .RESP_CYC(20000)) i_sdt_master (
    .clk(clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .line_txd(line_txd), .line_oe_n(line_oe_n), .line_rxd(line_rxd));

  sdt_drive_model #(.BIT(434), .NODE(5)) i_sdt_drive_model (
    .clk(clk), .line_txd(line_txd), .line_oe_n(line_oe_n),
    .slave_txd(slave_txd), .slave_oe_n(slave_oe_n));

  ////////////////////////////////////////
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    wb_sel   <= 4'hf;
    do @(posedge clk); while (wb_ack !== 1'b1);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp);
  endtask

  task automatic idle(output logic [31:0] s);
    do rd(`SDT_OFS_STAT, s); while (s[16] !== 1'b0);
  endtask

  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  initial begin
    logic [31:0] s;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(`SDT_OFS_CFG, `SDT_CFG_RST);
    rdc(`SDT_OFS_BAUD, {16'h0, `SDT_DIV_RST});
    rdc(`SDT_OFS_STAT, 32'h0);
    wr(10'h3f0, 32'hffff_ffff);
    rdc(10'h3f0, 32'h0);
    rdc(`SDT_OFS_CTRL, 32'h0);
    $display("test reset done");
    wr(`SDT_OFS_BAUD, {16'h0, `SDT_DIV_MIN});
    rdc(`SDT_OFS_BAUD, {16'h0, `SDT_DIV_MIN});
    foreach (bad_cfg[i]) begin
      wr(`SDT_OFS_CTRL, 32'h2);
      wr(`SDT_OFS_CFG, bad_cfg[i]);
      wr(`SDT_OFS_CTRL, 32'h1);
      rd(`SDT_OFS_STAT, s);
      chk(s & 32'h0001_00ff, 32'h0000_0040);
    end
    $display("test bad settings done");
    // mirror telegram, node 5, one process word carrying a byte value
    wr(`SDT_OFS_CTRL, 32'h2);
    wr(`SDT_OFS_CFG, 32'h0000_0145);
    wr(10'h100, 32'h00);
    wr(10'h104, 32'ha7);
    wr(`SDT_OFS_CTRL, 32'h1);
    wr(`SDT_OFS_CFG, 32'h0000_0025);
    rdc(`SDT_OFS_CFG, 32'h0000_0145);
    idle(s);
    chk(s, 32'h0400_0001);
    rdc(10'h100, 32'h00);
    rdc(10'h104, 32'ha7);
    $display("test mirror done");
    // broadcast must finish without waiting for a reply
    wr(`SDT_OFS_CTRL, 32'h2);
    wr(`SDT_OFS_CFG, 32'h0000_0025);
    wr(`SDT_OFS_CTRL, 32'h1);
    idle(s);
    chk(s & 32'h0001_00ff, 32'h0000_0001);
    $display("test broadcast done");
    end_of_test();
  end
endmodule // sdt_master_tb_top
